// File: cam_mask.sv
// acceptance mask sets with register port and filter comparison
//
// Chosen here: the address map and the address-and-strobe port.
`include "cam_params.svh"
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// [R1] There are three separate mask sets, 0 to 2, each with a standard and an extended mask register.
// [R2] A mask bit of one makes the message identifier bit have to equal the filter bit.
// [R3] A mask bit of zero makes that identifier bit a don't care.
// [R4] The extended mask register holds extended identifier bits 15 to 0 over its full width.
// [R5] Unimplemented mask register bits ignore writes and read as zero.
// [R6] With match type set the frame format must agree with the filter kind bit, otherwise either format matches.
module cam_mask
   import cam_pkg::*;
#(
   parameter int NSETS = `CAM_SETS
)
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire logic [`CAM_ADDR_W-1:0] addr,
   input wire logic [`CAM_DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [`CAM_DATA_W-1:0] rdata,
   // comparison request
   input wire logic cmp_valid,
   input wire logic [1:0] cmp_set,
   input wire logic [`CAM_SID_W-1:0] msg_sid,
   input wire logic [`CAM_EID_W-1:0] msg_eid,
   input wire logic msg_extended,
   input wire logic [`CAM_SID_W-1:0] flt_sid,
   input wire logic [`CAM_EID_W-1:0] flt_eid,
   input wire logic filter_frame_kind,
   // comparison answer
   output logic match_valid,
   output logic match
);
   cam_word_type sid_q [NSETS];
   cam_word_type eid_q [NSETS];
   logic match_d;
   logic hit_q;
   logic [`CAM_SID_W-1:0] sm;
   logic [`CAM_EID_W-1:0] em;
   logic mode;
   logic [`CAM_DATA_W-1:0] rdata_d;
   logic sid_eq;
   logic eid_eq;

   // standard mask writes
   always_ff @(posedge clk)
   begin
      for (int i = 0; i < NSETS; i++)
      begin
         if (reset)
         begin
            sid_q[i] <= `CAM_RST_VAL;
         end
         else if (wr && addr == `CAM_OFS_BASE + 4'(`CAM_SET_STRIDE * i)) // R1
         begin
            sid_q[i] <= wdata & `CAM_SID_IMPL; // R5
         end
      end
   end

   // extended mask writes
   always_ff @(posedge clk)
   begin
      for (int i = 0; i < NSETS; i++)
      begin
         if (reset)
         begin
            eid_q[i] <= `CAM_RST_VAL;
         end
         else if (wr && addr == `CAM_OFS_BASE + 4'(`CAM_SET_STRIDE * i + `CAM_EID_SLOT)) // R1
         begin
            eid_q[i] <= wdata; // R4
         end
      end
   end

   // read mux; unmapped reads zero
   always_comb
   begin
      rdata_d = `CAM_RST_VAL;
      for (int i = 0; i < NSETS; i++)
      begin
         if (addr == `CAM_OFS_BASE + 4'(`CAM_SET_STRIDE * i))
         begin
            rdata_d = sid_q[i]; // R5
         end
         if (addr == `CAM_OFS_BASE + 4'(`CAM_SET_STRIDE * i + `CAM_EID_SLOT))
         begin
            rdata_d = eid_q[i]; // R4
         end
      end
      if (addr == `CAM_OFS_STATUS)
      begin
         rdata_d[`CAM_HIT_BIT] = hit_q;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         rdata <= `CAM_RST_VAL;
      end
      else if (rd)
      begin
         rdata <= rdata_d;
      end
      else
      begin
         rdata <= `CAM_RST_VAL;
      end
   end

   // select mask set; an unused set index masks nothing
   always_comb
   begin
      sm = '0;
      em = '0;
      mode = 1'b0;
      for (int i = 0; i < NSETS; i++)
      begin
         if (cmp_set == 2'(i))
         begin
            sm = sid_q[i][`CAM_SID_HI:`CAM_SID_LO];
            em = {sid_q[i][`CAM_EIDH_HI:`CAM_EIDH_LO], eid_q[i]}; // R4
            mode = sid_q[i][`CAM_MODE_BIT];
         end
      end
   end

   // standard identifier field
   cam_field_eq #(
      .WIDTH(`CAM_SID_W)
   ) u_sid_eq (
      .msg_bits(msg_sid),
      .flt_bits(flt_sid),
      .mask_bits(sm),
      .equal(sid_eq)
   );

   // extended identifier field
   cam_field_eq #(
      .WIDTH(`CAM_EID_W)
   ) u_eid_eq (
      .msg_bits(msg_eid),
      .flt_bits(flt_eid),
      .mask_bits(em),
      .equal(eid_eq)
   );

   // combine fields and frame kind
   always_comb
   begin
      match_d = sid_eq; // R2 R3
      if (msg_extended)
      begin
         match_d = sid_eq && eid_eq; // R2 R3
      end
      if (mode && (msg_extended != filter_frame_kind))
      begin
         match_d = 1'b0; // R6
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         match_valid <= 1'b0;
         match <= 1'b0;
      end
      else
      begin
         match_valid <= cmp_valid;
         match <= cmp_valid && match_d;
      end
   end

   // last comparison result for status read
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         hit_q <= 1'b0;
      end
      else if (cmp_valid)
      begin
         hit_q <= match_d;
      end
   end
endmodule

// masked equality of one identifier field
module cam_field_eq
   import cam_pkg::*;
#(
   parameter int WIDTH = `CAM_SID_W
)
(
   // operands
   input wire logic [WIDTH-1:0] msg_bits,
   input wire logic [WIDTH-1:0] flt_bits,
   input wire logic [WIDTH-1:0] mask_bits,
   // result
   output logic equal
);
   logic [WIDTH-1:0] diff;

   // only bits with mask zero may differ
   always_comb
   begin
      diff = (msg_bits ^ flt_bits) & mask_bits; // R2 R3
      equal = (diff == '0);
   end
endmodule
`default_nettype wire

// File: cam_params.svh
// register map and field positions of the acceptance mask block
`ifndef CAM_PARAMS_SVH
`define CAM_PARAMS_SVH
`define CAM_ADDR_W 4
`define CAM_DATA_W 16
`define CAM_SETS 3
`define CAM_SID_W 11
`define CAM_EID_W 18
// word index: set n standard at 2n, extended at 2n+1
`define CAM_OFS_BASE 4'h0
`define CAM_OFS_STATUS 4'h8
`define CAM_SID_HI 15
`define CAM_SID_LO 5
`define CAM_MODE_BIT 3
`define CAM_EIDH_HI 1
`define CAM_EIDH_LO 0
`define CAM_SID_IMPL 16'hFFEB
`define CAM_RST_VAL 16'h0000
`define CAM_SET_STRIDE 2
`define CAM_EID_SLOT 1
`define CAM_HIT_BIT 0
`endif

// File: cam_pkg.sv
// types shared by the acceptance mask block
package cam_pkg;
   typedef logic [15:0] cam_word_type;
endpackage

// File: cam_mask_assertions.sv
// port assertions of the mask block
`timescale 1ns/1ns
`default_nettype none
module cam_mask_chk(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   // comparison
   input wire logic cmp_valid,
   input wire logic [1:0] cmp_set,
   input wire logic [10:0] msg_sid,
   input wire logic [17:0] msg_eid,
   input wire logic msg_extended,
   input wire logic [10:0] flt_sid,
   input wire logic [17:0] flt_eid,
   input wire logic filter_frame_kind,
   input wire logic match_valid,
   input wire logic match
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_wr1; wr && addr == 4'h1 ##1 rd && addr == 4'h1; endsequence
   property p_un; rd && addr[3:1] == 3'h3 |=> rdata == 16'h0000; endproperty
   a_un: assert property (p_un) else $error("unmapped");
   property p_eq; cmp_valid && msg_sid == flt_sid && msg_eid == flt_eid
      && msg_extended == filter_frame_kind |=> match; endproperty
   a_eq: assert property (p_eq) else $error("equal");
   property p_mv; cmp_valid |=> match_valid; endproperty
   a_mv: assert property (p_mv) else $error("answer");
   property p_dc; cmp_valid && cmp_set == 2'h3 |=> match; endproperty
   a_dc: assert property (p_dc) else $error("ignore");
   property p_rw; s_wr1 |=> rdata == $past(wdata, 2); endproperty
   a_rw: assert property (p_rw) else $error("ext");
   property p_ub; rd && !addr[0] |=> !rdata[4] && !rdata[2]; endproperty
   a_ub: assert property (p_ub) else $error("unimpl");
   property p_nv; !cmp_valid |=> !match_valid && !match; endproperty
   a_nv: assert property (p_nv) else $error("no answer");
   property p_rz; !rd |=> rdata == 16'h0000; endproperty
   a_rz: assert property (p_rz) else $error("idle read");
endmodule
bind cam_mask cam_mask_chk u_chk(
   .clk(clk),
   .reset(reset),
   .addr(addr),
   .wdata(wdata),
   .wr(wr),
   .rd(rd),
   .rdata(rdata),
   .cmp_valid(cmp_valid),
   .cmp_set(cmp_set),
   .msg_sid(msg_sid),
   .msg_eid(msg_eid),
   .msg_extended(msg_extended),
   .flt_sid(flt_sid),
   .flt_eid(flt_eid),
   .filter_frame_kind(filter_frame_kind),
   .match_valid(match_valid),
   .match(match)
);
`default_nettype wire

// File: cam_node.sv
// identifier of a frame from a remote node
`timescale 1ns/1ns
`default_nettype none
module cam_node(
   output logic [10:0] standard_identifier_mask_bits,
   output logic [17:0] extended_identifier_mask_bits,
   output logic ext
);
   assign {standard_identifier_mask_bits, extended_identifier_mask_bits, ext} = 30'h2D5AB3C5;
endmodule
`default_nettype wire

// File: tb_cam_mask.sv
// bench for the mask block
`timescale 1ns/1ns
`default_nettype none
module tb_cam_mask;
   logic clk = 0, reset = 1, wr = 0, rd = 0, cmp_valid = 0, filter_frame_kind = 0;
   logic match_valid, match, msg_extended;
   logic [3:0] addr = 0;
   logic [1:0] cmp_set = 0;
   logic [15:0] wdata = 0, rdata;
   logic [10:0] msg_sid, flt_sid = 0;
   logic [17:0] msg_eid, flt_eid = 0;
   int num_errors = 0, num_checks = 0, cyc = 0;
   always #20 clk = ~clk;
   cam_node u_node(.standard_identifier_mask_bits(msg_sid), .extended_identifier_mask_bits(msg_eid), .ext(msg_extended));
   cam_mask u_dut(
      .clk(clk),
      .reset(reset),
      .addr(addr),
      .wdata(wdata),
      .wr(wr),
      .rd(rd),
      .rdata(rdata),
      .cmp_valid(cmp_valid),
      .cmp_set(cmp_set),
      .msg_sid(msg_sid),
      .msg_eid(msg_eid),
      .msg_extended(msg_extended),
      .flt_sid(flt_sid),
      .flt_eid(flt_eid),
      .filter_frame_kind(filter_frame_kind),
      .match_valid(match_valid),
      .match(match)
   );
   task ck(input logic [15:0] s, e);
      num_checks++;
      if (s !== e)
      begin
         num_errors++;
         $display("mismatch %0t seen %h want %h", $time, s, e);
      end
   endtask
   task give_verdict;
      if (num_errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task op(input logic [2:0] s, input logic [3:0] a, input logic [15:0] d,
      input logic [10:0] f, input logic [17:0] g, input logic [2:0] m);
      @(posedge clk);
      {wr, rd, cmp_valid, addr, wdata, flt_sid, flt_eid, cmp_set, filter_frame_kind}
         <= {s, a, d, msg_sid ^ f, msg_eid ^ g, m};
   endtask
   task idle;
      op(3'h0, 4'h0, 16'h0000, 11'h000, 18'h00000, 3'h0);
   endtask
   task wt(input logic [3:0] a, input logic [15:0] d);
      op(3'h4, a, d, 11'h000, 18'h00000, 3'h0);
   endtask
   task rc(input logic [3:0] a, input logic [15:0] e);
      op(3'h2, a, 16'h0000, 11'h000, 18'h00000, 3'h0);
      idle;
      #1 ck(rdata, e);
      idle;
      #1 ck(rdata, 16'h0000);
   endtask
   task cc(input logic [10:0] f, input logic [17:0] g, input logic [2:0] m, input logic e);
      op(3'h1, 4'h0, 16'h0000, f, g, m);
      idle;
      #1 ck({14'h0, match_valid, match}, {14'h0, 1'b1, e});
      idle;
      #1 ck({14'h0, match_valid, match}, 16'h0000);
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc > 400)
      begin
         num_errors++;
         give_verdict;
      end
   end
   initial
   begin
      repeat (16) @(posedge clk);
      reset <= 0;
      wt(4'h0, 16'hFFFF);
      rc(4'h0, 16'hFFEB);
      wt(4'h1, 16'hFFFF);
      rc(4'h1, 16'hFFFF);
      wt(4'h4, 16'hFFE0);
      wt(4'h5, 16'h0000);
      rc(4'h4, 16'hFFE0);
      rc(4'h2, 16'h0000);
      rc(4'h7, 16'h0000);
      cc(11'h000, 18'h00000, 3'h1, 1'b1);
      cc(11'h001, 18'h00000, 3'h1, 1'b0);
      cc(11'h000, 18'h00001, 3'h1, 1'b0);
      cc(11'h000, 18'h20000, 3'h1, 1'b0);
      cc(11'h000, 18'h00000, 3'h0, 1'b0);
      cc(11'h000, 18'h3FFFF, 3'h4, 1'b1);
      cc(11'h7FF, 18'h3FFFF, 3'h2, 1'b1);
      cc(11'h7FF, 18'h3FFFF, 3'h6, 1'b1);
      rc(4'h8, 16'h0001);
      @(posedge clk);
      reset <= 1;
      @(posedge clk);
      reset <= 0;
      rc(4'h0, 16'h0000);
      give_verdict;
   end
endmodule
`default_nettype wire
